// [logic/spdc_regs.sv]
// device control register bank of one switch port, apb slave
//
// Design decision made here: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module spdc_regs
   import spdc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic [DATA_W-1:0] prdata,
   output logic pslverr,
   input wire logic strap_mps_512,
   input wire logic [3:0] err_detect,
   output logic [3:0] err_msg,
   output logic [2:0] max_payload_code,
   output logic [9:0] max_payload_bytes,
   output logic aux_power_enable,
   output logic irq
);

   //==============================================================
   // state
   typedef struct packed {
      logic strap_s1;
      logic strap_s2;
      logic [2:0] cap;
      logic [3:0] err_en;
      logic [2:0] mps;
      logic aux_en;
      logic [3:0] err_seen;
      logic [3:0] irq_st;
      logic [3:0] irq_mask;
      logic [3:0] msg;
      logic [9:0] bytes;
      logic irq;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } spdc_state_s;

   localparam spdc_state_s ST_RST = '{
      strap_s1: 1'b0,
      strap_s2: 1'b0,
      cap: MPS_256,
      err_en: EN_RST,
      mps: MPS_RST,
      aux_en: AUX_RST,
      err_seen: 4'h0,
      irq_st: 4'h0,
      irq_mask: MASK_RST,
      msg: 4'h0,
      bytes: BYTES_128,
      irq: 1'b0,
      pready: 1'b0,
      pslverr: 1'b0,
      prdata: 32'h0
   };

   spdc_state_s st;
   spdc_state_s next_st;

   //==============================================================
   // decoding
   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      is_mapped = (a == OFS_CAP) || (a == OFS_CTRL) || (a == OFS_IRQ_ST) || (a == OFS_IRQ_MASK);
   endfunction

   // reserved codes exceed every capability, so the clamp also covers them
   function automatic logic [2:0] clamp_mps(input logic [2:0] code, input logic [2:0] cap);
      clamp_mps = (code > cap) ? cap : code;
   endfunction

   function automatic logic [9:0] mps_bytes(input logic [2:0] code);
      unique case (code)
         MPS_128: mps_bytes = BYTES_128;
         MPS_256: mps_bytes = BYTES_256;
         MPS_512: mps_bytes = BYTES_512;
         default: mps_bytes = BYTES_128;
      endcase
   endfunction

   //==============================================================
   // bus phases
   logic access_first;
   logic access_done;
   logic wr_commit;

   // one wait state: read data is latched on the first access edge, writes commit on the second
   assign access_first = psel && penable && !st.pready;
   assign access_done = psel && penable && st.pready;
   assign wr_commit = access_done && pwrite && is_mapped(paddr);

   //==============================================================
   // next state
   always_comb begin
      next_st = st;
      // strap is static; sampled through two flops all the same
      next_st.strap_s1 = strap_mps_512;
      next_st.strap_s2 = st.strap_s1;
      next_st.cap = st.strap_s2 ? MPS_512 : MPS_256;
      next_st.pready = 1'b0;
      next_st.pslverr = 1'b0;
      next_st.msg = err_detect & st.err_en;
      if (access_first) begin
         next_st.pready = 1'b1;
         next_st.pslverr = !is_mapped(paddr);
         next_st.prdata = 32'h0;
         if (!pwrite) begin
            unique case (paddr)
               OFS_CAP: next_st.prdata = {29'h0, st.cap};
               // bits 4, 8, 9, 11, 15:12 and above 19 are constant zero
               OFS_CTRL: next_st.prdata = {12'h0, st.err_seen, 5'h0, st.aux_en, 2'h0, st.mps, 1'b0,
                                           st.err_en};
               OFS_IRQ_ST: next_st.prdata = {28'h0, st.irq_st};
               OFS_IRQ_MASK: next_st.prdata = {28'h0, st.irq_mask};
               default: next_st.prdata = 32'h0;
            endcase
         end
      end
      if (wr_commit) begin
         unique case (paddr)
            OFS_CTRL: begin
               if (pstrb[0]) begin
                  next_st.err_en = pwdata[EN_LSB+:EN_W];
                  next_st.mps = clamp_mps(pwdata[MPS_LSB+:MPS_W], st.cap);
               end
               if (pstrb[1]) begin
                  next_st.aux_en = pwdata[AUX_BIT];
               end
               if (pstrb[2]) begin
                  next_st.err_seen = st.err_seen & ~pwdata[SEEN_LSB+:EN_W];
               end
            end
            OFS_IRQ_ST: begin
               if (pstrb[0]) begin
                  next_st.irq_st = st.irq_st & ~pwdata[3:0];
               end
            end
            OFS_IRQ_MASK: begin
               if (pstrb[0]) begin
                  next_st.irq_mask = pwdata[3:0];
               end
            end
            default: begin
            end
         endcase
      end
      // set wins over a clear in the same cycle
      for (int i = 0; i < EN_W; i++) begin
         if (err_detect[i]) begin
            next_st.err_seen[i] = 1'b1;
            next_st.irq_st[i] = 1'b1;
         end
      end
      next_st.bytes = mps_bytes(next_st.mps);
      next_st.irq = |(next_st.irq_st & next_st.irq_mask);
   end

   //==============================================================
   // registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= ST_RST;
      end else begin
         st <= next_st;
      end
   end

   //==============================================================
   // outputs
   assign pready = st.pready;
   assign prdata = st.prdata;
   assign pslverr = st.pslverr;
   assign err_msg = st.msg;
   assign max_payload_code = st.mps;
   assign max_payload_bytes = st.bytes;
   assign aux_power_enable = st.aux_en;
   assign irq = st.irq;

   //==============================================================
   // assertions
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   logic wr_ctrl_lo;
   logic wr_ctrl_hi;
   logic rd_ctrl_done;
   logic wr_ctrl_seen;
   assign wr_ctrl_seen = wr_commit && (paddr == OFS_CTRL) && pstrb[2];
   assign wr_ctrl_lo = wr_commit && (paddr == OFS_CTRL) && pstrb[0];
   assign wr_ctrl_hi = wr_commit && (paddr == OFS_CTRL) && pstrb[1];
   assign rd_ctrl_done = access_done && !pwrite && (paddr == OFS_CTRL);

   property p_ce_write;
      wr_ctrl_lo |=> (st.err_en[0] == $past(pwdata[0]));
   endproperty
   a_ce_write: assert property (p_ce_write) else $error("correctable enable not written");

   property p_nfe_write;
      wr_ctrl_lo |=> (st.err_en[1] == $past(pwdata[1]));
   endproperty
   a_nfe_write: assert property (p_nfe_write) else $error("non-fatal enable not written");

   property p_fe_write;
      wr_ctrl_lo |=> (st.err_en[2] == $past(pwdata[2]));
   endproperty
   a_fe_write: assert property (p_fe_write) else $error("fatal enable not written");

   property p_ur_write;
      wr_ctrl_lo |=> (st.err_en[3] == $past(pwdata[3]));
   endproperty
   a_ur_write: assert property (p_ur_write) else $error("unsupported request enable not written");

   property p_ro_zero;
      rd_ctrl_done |-> (prdata[4] == 1'b0) && (prdata[11] == 1'b0);
   endproperty
   a_ro_zero: assert property (p_ro_zero) else $error("ordering or snoop bit read nonzero");

   property p_tag_phantom_zero;
      rd_ctrl_done |-> (prdata[9:8] == 2'h0);
   endproperty
   a_tag_phantom_zero: assert property (p_tag_phantom_zero) else $error("tag or phantom bit set");

   property p_upper_zero;
      rd_ctrl_done |-> (prdata[15:12] == 4'h0);
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("read request or reserved bits set");

   property p_mps_clamp;
      wr_ctrl_lo |=> (max_payload_code == (($past(pwdata[7:5]) > $past(st.cap)) ? $past(st.cap)
                                           : $past(pwdata[7:5])));
   endproperty
   a_mps_clamp: assert property (p_mps_clamp) else $error("payload size not clamped");

   property p_mps_legal;
      max_payload_code <= MPS_512;
   endproperty
   a_mps_legal: assert property (p_mps_legal) else $error("payload size above capability");

   property p_bytes;
      max_payload_bytes == mps_bytes(max_payload_code);
   endproperty
   a_bytes: assert property (p_bytes) else $error("payload byte count wrong");

   property p_aux_write;
      wr_ctrl_hi |=> (aux_power_enable == $past(pwdata[10]));
   endproperty
   a_aux_write: assert property (p_aux_write) else $error("aux power enable not written");

   property p_seen;
      (err_detect != 4'h0) |=> ((st.err_seen & $past(err_detect)) == $past(err_detect));
   endproperty
   a_seen: assert property (p_seen) else $error("detection not logged");

   property p_msg;
      ##1 (err_msg == ($past(err_detect) & $past(st.err_en)));
   endproperty
   a_msg: assert property (p_msg) else $error("message gating wrong");

   property p_irq;
      irq == |(st.irq_st & st.irq_mask);
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt level wrong");

   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready held two cycles");

   property p_one_wait;
      access_first |=> pready;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("pready not after one wait state");

   property p_err_with_ready;
      pslverr |-> pready;
   endproperty
   a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr without pready");

   property p_unmapped_err;
      (access_first && !is_mapped(paddr)) |=> pslverr;
   endproperty
   a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped access not refused");

   property p_unmapped_rd;
      (access_first && !pwrite && !is_mapped(paddr)) |=> (prdata == 32'h0);
   endproperty
   a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");

   property p_high_zero;
      rd_ctrl_done |-> (prdata[31:20] == 12'h0);
   endproperty
   a_high_zero: assert property (p_high_zero) else $error("control upper bits set");

   property p_en_hold;
      !wr_ctrl_lo |=> $stable(st.err_en);
   endproperty
   a_en_hold: assert property (p_en_hold) else $error("enables changed without write");

   // capability drop after a write leaves the stored code alone
   property p_mps_hold;
      !wr_ctrl_lo |=> $stable(max_payload_code);
   endproperty
   a_mps_hold: assert property (p_mps_hold) else $error("payload size changed without write");

   property p_aux_hold;
      !wr_ctrl_hi |=> $stable(aux_power_enable);
   endproperty
   a_aux_hold: assert property (p_aux_hold) else $error("aux power enable changed without write");

   property p_msg_off;
      (err_msg & ~$past(st.err_en)) == 4'h0;
   endproperty
   a_msg_off: assert property (p_msg_off) else $error("message sent while disabled");

   property p_cap_legal;
      (st.cap == MPS_256) || (st.cap == MPS_512);
   endproperty
   a_cap_legal: assert property (p_cap_legal) else $error("capability code reserved");

   property p_seen_clear;
      (wr_ctrl_seen && (err_detect == 4'h0)) |=> ((st.err_seen & $past(pwdata[19:16])) == 4'h0);
   endproperty
   a_seen_clear: assert property (p_seen_clear) else $error("detected flag not cleared");

   property p_seen_hold;
      (!wr_ctrl_seen && (err_detect == 4'h0)) |=> $stable(st.err_seen);
   endproperty
   a_seen_hold: assert property (p_seen_hold) else $error("detected flags changed without cause");

   c_clamp: cover property (wr_ctrl_lo && (pwdata[7:5] > st.cap));
   c_msg: cover property (err_msg != 4'h0);
   c_irq: cover property ($rose(irq));
   c_unmapped: cover property (pready && pslverr);
   c_seen_clr: cover property (wr_ctrl_seen && (st.err_seen != 4'h0));

endmodule
`default_nettype wire

// [pkg/spdc_pkg.sv]
// constants of the switch port device control register bank
//==============================================================
`default_nettype none
package spdc_pkg;
   //==============================================================
   // bus and map
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam logic [11:0] OFS_CAP = 12'h0c4;
   localparam logic [11:0] OFS_CTRL = 12'h0c8;
   localparam logic [11:0] OFS_IRQ_ST = 12'h100;
   localparam logic [11:0] OFS_IRQ_MASK = 12'h104;
   //==============================================================
   // field positions of the control word
   localparam int EN_LSB = 0;
   localparam int EN_W = 4;
   localparam int MPS_LSB = 5;
   localparam int MPS_W = 3;
   localparam int AUX_BIT = 10;
   localparam int SEEN_LSB = 16;
   //==============================================================
   // payload codes and reset values
   localparam logic [2:0] MPS_128 = 3'h0;
   localparam logic [2:0] MPS_256 = 3'h1;
   localparam logic [2:0] MPS_512 = 3'h2;
   localparam logic [9:0] BYTES_128 = 10'h080;
   localparam logic [9:0] BYTES_256 = 10'h100;
   localparam logic [9:0] BYTES_512 = 10'h200;
   localparam logic [3:0] EN_RST = 4'h0;
   localparam logic [2:0] MPS_RST = 3'h0;
   localparam logic AUX_RST = 1'b0;
   localparam logic [3:0] MASK_RST = 4'h0;
endpackage
`default_nettype wire

// [testbench/tb_top.sv]
// self-checking bench of the switch port device control bank
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import spdc_pkg::*;
();
   //==============================================================
   // signals
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [DATA_W-1:0] pwdata = '0;
   logic [3:0] pstrb = 4'h0;
   logic pready;
   logic [DATA_W-1:0] prdata;
   logic pslverr;
   logic strap_mps_512 = 1'b1;
   logic [3:0] err_detect = 4'h0;
   logic [3:0] err_msg;
   logic [2:0] max_payload_code;
   logic [9:0] max_payload_bytes;
   logic aux_power_enable;
   logic irq;
   logic [31:0] rdat;
   logic rerr;
   logic [31:0] sh;
   logic [31:0] d;
   logic [3:0] det;
   logic [3:0] en;
   logic [3:0] mk;
   logic [2:0] cap;
   int n_mismatch = 0;
   int total_checks = 0;

   always #2 pclk = ~pclk;

   spdc_regs i_spdc_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .strap_mps_512(strap_mps_512), .err_detect(err_detect), .err_msg(err_msg),
      .max_payload_code(max_payload_code), .max_payload_bytes(max_payload_bytes),
      .aux_power_enable(aux_power_enable), .irq(irq));

   //==============================================================
   // helpers
   function automatic logic [31:0] exp_ctrl(input logic [31:0] w, input logic [2:0] c);
      logic [2:0] m;
      m = (w[7:5] > c) ? c : w[7:5];
      exp_ctrl = {21'h0, w[10], 2'h0, m, 1'b0, w[3:0]};
   endfunction

   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      total_checks++;
      if (got !== ex) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
         n_mismatch++;
      end
   endtask

   // one transfer; the answer is taken at the edge where pready is seen
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, input logic [3:0] s);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) begin
         $display("CHECK FAILED pready expected 1 seen timeout");
         n_mismatch++;
         conclude();
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic outs();
      #1;
      chk("code", {29'h0, sh[7:5]}, {29'h0, max_payload_code});
      chk("bytes", {22'h0, BYTES_128 << sh[7:5]}, {22'h0, max_payload_bytes});
      chk("aux", {31'h0, sh[10]}, {31'h0, aux_power_enable});
      apb(1'b0, OFS_CTRL, 32'h0, 4'h0);
      chk("ctrl", sh, rdat);
   endtask

   //==============================================================
   // main sequence
   initial begin
      void'($urandom(27905));
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      repeat (5) @(posedge pclk);
      sh = 32'h0;
      outs();
      chk("irq", 32'h0, {31'h0, irq});
      // capability 512, then 256 after the strap drops
      for (int p = 0; p < 2; p++) begin
         cap = (p == 0) ? MPS_512 : MPS_256;
         apb(1'b1, OFS_CAP, 32'hffff_ffff, 4'hf);
         apb(1'b0, OFS_CAP, 32'h0, 4'h0);
         chk("cap", {29'h0, cap}, {29'h0, rdat[2:0]});
         for (int i = 0; i < 16; i++) begin
            d = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0000_0040 : (i == 2) ? 32'h0000_0020 : $urandom;
            apb(1'b1, OFS_CTRL, d, 4'h3);
            sh = exp_ctrl(d, cap);
            outs();
         end
         apb(1'b1, OFS_CTRL, ~sh, 4'h0);
         outs();
         strap_mps_512 <= 1'b0;
         repeat (5) @(posedge pclk);
      end
      // unmapped place: refused, reads zero
      apb(1'b1, 12'h010, 32'hffff_ffff, 4'hf);
      chk("err_w", 32'h1, {31'h0, rerr});
      apb(1'b0, 12'h010, 32'h0, 4'h0);
      chk("err_r", 32'h1, {31'h0, rerr});
      chk("rd_unmap", 32'h0, rdat);
      // events: logged always, reported only when enabled
      for (int i = 0; i < 10; i++) begin
         en = (i == 0) ? 4'h0 : 4'($urandom);
         mk = (i == 1) ? 4'h0 : 4'($urandom);
         det = (i < 2) ? 4'hf : 4'($urandom);
         d = {sh[31:4], en};
         apb(1'b1, OFS_CTRL, d, 4'h1);
         sh = exp_ctrl(d, MPS_256);
         apb(1'b1, OFS_IRQ_MASK, {28'h0, mk}, 4'hf);
         @(posedge pclk);
         err_detect <= det;
         @(posedge pclk);
         err_detect <= 4'h0;
         #1;
         chk("err_msg", {28'h0, det & en}, {28'h0, err_msg});
         #1;
         chk("irq", {31'h0, |(det & mk)}, {31'h0, irq});
         apb(1'b0, OFS_CTRL, 32'h0, 4'h0);
         chk("seen", sh | {12'h0, det, 16'h0}, rdat);
         apb(1'b0, OFS_IRQ_ST, 32'h0, 4'h0);
         chk("irq_st", {28'h0, det}, rdat);
         apb(1'b1, OFS_IRQ_ST, {28'h0, det}, 4'hf);
         apb(1'b1, OFS_CTRL, sh | {12'h0, det, 16'h0}, 4'h7);
         #1;
         chk("irq_clr", 32'h0, {31'h0, irq});
         apb(1'b0, OFS_IRQ_ST, 32'h0, 4'h0);
         chk("irq_st_clr", 32'h0, rdat);
         outs();
      end
      conclude();
   end
endmodule
`default_nettype wire
